// >>> pkg/mcuxt_pkg.sv
// shared constants, opcodes and carriers for the instruction execute tail
package mcuxt_pkg;

  // register byte offsets on the control bus
  localparam logic [11:0] MCUXT_REG_INSTR = 12'h000;
  localparam logic [11:0] MCUXT_REG_WORK = 12'h004;
  localparam logic [11:0] MCUXT_REG_FLAGS = 12'h008;
  localparam logic [11:0] MCUXT_REG_TPTR_LOW = 12'h00C;
  localparam logic [11:0] MCUXT_REG_TPTR_HIGH = 12'h010;
  localparam logic [11:0] MCUXT_REG_TREAD_HIGH = 12'h014;
  localparam logic [11:0] MCUXT_REG_STATE = 12'h018;
  // data memory window: one byte per word from this base
  localparam logic [1:0] MCUXT_DMEM_SEL = 2'h1;
  localparam int MCUXT_DMEM_SEL_LSB = 10;

  // status register bit positions
  localparam int MCUXT_ST_BUSY = 0;
  localparam int MCUXT_ST_DISCARD = 1;

  // values after reset and fixed data values
  localparam logic [7:0] MCUXT_BYTE_RESET = 8'h00;
  localparam logic [7:0] MCUXT_ALL_ONES = 8'hFF;
  localparam logic [7:0] MCUXT_ONE = 8'h01;
  localparam logic [1:0] MCUXT_RESP_OKAY = 2'h0;
  localparam logic [1:0] MCUXT_RESP_SLVERR = 2'h2;

  // instruction codes carried in the instruction register
  typedef enum logic [4:0] {
    OP_NO_OPERATION = 5'h00,
    OP_SUBTRACT_BORROW_TO_W = 5'h01,
    OP_SUBTRACT_BORROW_TO_MEMORY = 5'h02,
    OP_SUBTRACT_TO_W = 5'h03,
    OP_SUBTRACT_TO_MEMORY = 5'h04,
    OP_SUBTRACT_IMMEDIATE = 5'h05,
    OP_DECREMENT_SKIP_NIL = 5'h06,
    OP_DECREMENT_SKIP_NIL_TO_W = 5'h07,
    OP_INCREMENT_SKIP_NIL = 5'h08,
    OP_INCREMENT_SKIP_NIL_TO_W = 5'h09,
    OP_SKIP_BIT_SET = 5'h0A,
    OP_SKIP_BIT_CLEAR = 5'h0B,
    OP_SKIP_IF_NIL = 5'h0C,
    OP_COPY_SKIP_IF_NIL = 5'h0D,
    OP_SET_BYTE = 5'h0E,
    OP_SET_BIT = 5'h0F,
    OP_NIBBLE_EXCHANGE = 5'h10,
    OP_NIBBLE_EXCHANGE_TO_W = 5'h11,
    OP_TABLE_FETCH_PAGED = 5'h12,
    OP_TABLE_FETCH_CURRENT_PAGE = 5'h13,
    OP_TABLE_FETCH_LAST_PAGE = 5'h14,
    OP_EXCLUSIVE_OR_TO_W = 5'h15,
    OP_EXCLUSIVE_OR_TO_MEMORY = 5'h16,
    OP_EXCLUSIVE_OR_IMMEDIATE = 5'h17
  } mcuxt_opcode_type;

  // instruction word as written to the instruction register, bits 23..0
  typedef struct packed {
    logic [7:0] immediate;
    logic [7:0] mem_addr;
    logic [2:0] bit_sel;
    mcuxt_opcode_type opcode;
  } mcuxt_instr_type;

  // status flags, bits 3..0 of the flags register
  typedef struct packed {
    logic signed_range_flag;
    logic zero_flag;
    logic half_borrow_flag;
    logic borrow_flag;
  } mcuxt_flags_type;

  // execution sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_EXEC = 3'b001,
    ST_SKIP = 3'b011,
    ST_TREQ = 3'b101,
    ST_TCAP = 3'b111
  } mcuxt_state_type;

endpackage : mcuxt_pkg

// >>> rtl/mcuxt_exec.sv
// instruction execute tail: subtract, skip, set, swap, table read and xor
// Operation
// - borrow subtract to memory: w minus operand minus inverted borrow; four flags
// - subtract borrow flag: 0 if negative, 1 if zero or positive
// - plain subtract of memory or immediate into w or memory; four flags
// - decrement memory in place; skip when zero; no flags
// - decrement into w, memory kept; skip when zero
// - increment memory in place; skip when zero; no flags
// - increment into w, memory kept; skip when zero
// - a taken skip adds one dummy cycle
// - skip when the selected bit is one
// - skip when the selected bit is zero
// - skip when the operand is zero
// - copy operand to w, skip when zero; no flags
// - set byte writes all ones; no flags
// - set bit forces only the selected bit
// - nibble exchange into memory or w; no flags
// - paged table read: low byte to memory, high byte kept
// - table read on the current page
// - table read on the last page
// - xor of w with operand or immediate; zero flag only
`timescale 1ns/1ps

module mcuxt_exec
  import mcuxt_pkg::*;
#(
  parameter int DMEM_DEPTH = 256,
  parameter int PA_W = 12,
  parameter int PW_W = 16
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [11:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // program memory read port, word arrives the cycle after the strobe
  output logic [PA_W-1:0] pmem_addr,
  output logic pmem_rd,
  input wire logic [PW_W-1:0] pmem_rdata,
  // fetch logic view
  input wire logic [PA_W-9:0] current_page,
  output logic busy,
  output logic skip_taken
);

  localparam int DA_W = $clog2(DMEM_DEPTH);

  mcuxt_state_type state_q;
  mcuxt_instr_type instr_q;
  mcuxt_flags_type flags_q;
  logic [7:0] dmem_q [DMEM_DEPTH];
  logic [7:0] working_register_q, table_pointer_low_q, table_pointer_high_q;
  logic [7:0] table_read_high_byte_q;
  logic go_q, discard_q, skip_taken_q, pmem_rd_q;
  logic [PA_W-1:0] pmem_addr_q;

  // bus holding registers
  logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
  logic [11:0] aw_addr_q;
  logic [31:0] w_data_q, rdata_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q, rresp_q;

  // execution decode results
  logic exec_en, wr_mem, wr_w, upd_arith, upd_zero, skip_cond, is_table, borrow_in;
  logic [7:0] operand, result, sub_rhs;
  logic [PA_W-1:0] table_addr;
  logic [8:0] diff;
  logic [4:0] half_diff;

  // write decode
  logic do_write, wsel_instr, wsel_work, wsel_flags, wsel_tlow, wsel_thigh, wsel_dmem, wsel_ro;

  // bus write channel: address and data taken in either order
  assign s_axi_awready = ~aw_hold_q;
  assign s_axi_wready = ~w_hold_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  // writes wait for an idle sequencer so they never race an instruction
  assign do_write = aw_hold_q & w_hold_q & ~bvalid_q & (state_q == ST_IDLE) & ~go_q;

  assign wsel_instr = (aw_addr_q == MCUXT_REG_INSTR);
  assign wsel_work = (aw_addr_q == MCUXT_REG_WORK);
  assign wsel_flags = (aw_addr_q == MCUXT_REG_FLAGS);
  assign wsel_tlow = (aw_addr_q == MCUXT_REG_TPTR_LOW);
  assign wsel_thigh = (aw_addr_q == MCUXT_REG_TPTR_HIGH);
  assign wsel_ro = (aw_addr_q == MCUXT_REG_TREAD_HIGH) | (aw_addr_q == MCUXT_REG_STATE);
  assign wsel_dmem = (aw_addr_q[11:MCUXT_DMEM_SEL_LSB] == MCUXT_DMEM_SEL)
                   & (int'(aw_addr_q[MCUXT_DMEM_SEL_LSB-1:2]) < DMEM_DEPTH);

  // address and data holding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= 12'h000;
      w_hold_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_hold_q) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= {s_axi_awaddr[11:2], 2'h0};
      end else if (do_write) begin
        aw_hold_q <= 1'b0;
      end
      if (s_axi_wvalid && !w_hold_q) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  // write response, error for unmapped words
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= MCUXT_RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= (wsel_instr | wsel_work | wsel_flags | wsel_tlow | wsel_thigh | wsel_ro
                  | wsel_dmem) ? MCUXT_RESP_OKAY : MCUXT_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // instruction register: a write issues the instruction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instr_q <= '0;
      go_q <= 1'b0;
    end else begin
      go_q <= do_write & wsel_instr;
      if (do_write && wsel_instr) begin
        instr_q.opcode <= w_strb_q[0] ? mcuxt_opcode_type'(w_data_q[4:0]) : OP_NO_OPERATION;
        instr_q.bit_sel <= w_strb_q[0] ? w_data_q[7:5] : 3'h0;
        instr_q.mem_addr <= w_strb_q[1] ? w_data_q[15:8] : MCUXT_BYTE_RESET;
        instr_q.immediate <= w_strb_q[2] ? w_data_q[23:16] : MCUXT_BYTE_RESET;
      end
    end
  end

  // bus read channel, one outstanding read
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= MCUXT_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rresp_q <= MCUXT_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      if (s_axi_araddr[11:MCUXT_DMEM_SEL_LSB] == MCUXT_DMEM_SEL &&
          int'(s_axi_araddr[MCUXT_DMEM_SEL_LSB-1:2]) < DMEM_DEPTH) begin
        rdata_q[7:0] <= dmem_q[s_axi_araddr[DA_W+1:2]];
      end else begin
        unique case ({s_axi_araddr[11:2], 2'h0})
          MCUXT_REG_INSTR: rdata_q[23:0] <= instr_q;
          MCUXT_REG_WORK: rdata_q[7:0] <= working_register_q;
          MCUXT_REG_FLAGS: rdata_q[3:0] <= flags_q;
          MCUXT_REG_TPTR_LOW: rdata_q[7:0] <= table_pointer_low_q;
          MCUXT_REG_TPTR_HIGH: rdata_q[7:0] <= table_pointer_high_q;
          MCUXT_REG_TREAD_HIGH: rdata_q[7:0] <= table_read_high_byte_q;
          MCUXT_REG_STATE: begin
            rdata_q[MCUXT_ST_BUSY] <= busy;
            rdata_q[MCUXT_ST_DISCARD] <= discard_q;
          end
          default: rresp_q <= MCUXT_RESP_SLVERR;
        endcase
      end
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // instruction decode and datapath, evaluated in the execute cycle
  assign exec_en = (state_q == ST_EXEC) & ~discard_q;
  assign operand = dmem_q[instr_q.mem_addr[DA_W-1:0]];
  assign sub_rhs = (instr_q.opcode == OP_SUBTRACT_IMMEDIATE ||
                    instr_q.opcode == OP_EXCLUSIVE_OR_IMMEDIATE) ? instr_q.immediate : operand;
  // borrow in is the inverted borrow flag only for the with-borrow forms
  assign borrow_in = ((instr_q.opcode == OP_SUBTRACT_BORROW_TO_W) ||
                      (instr_q.opcode == OP_SUBTRACT_BORROW_TO_MEMORY)) & ~flags_q.borrow_flag;
  assign diff = {1'b0, working_register_q} - {1'b0, sub_rhs} - {8'h00, borrow_in};
  assign half_diff = {1'b0, working_register_q[3:0]} - {1'b0, sub_rhs[3:0]} - {4'h0, borrow_in};

  always_comb begin
    result = MCUXT_BYTE_RESET;
    wr_mem = 1'b0;
    wr_w = 1'b0;
    upd_arith = 1'b0;
    upd_zero = 1'b0;
    skip_cond = 1'b0;
    is_table = 1'b0;
    table_addr = '0;
    unique case (instr_q.opcode)
      OP_SUBTRACT_BORROW_TO_W, OP_SUBTRACT_TO_W, OP_SUBTRACT_IMMEDIATE: begin
        result = diff[7:0];
        wr_w = 1'b1;
        upd_arith = 1'b1;
      end
      OP_SUBTRACT_BORROW_TO_MEMORY, OP_SUBTRACT_TO_MEMORY: begin
        result = diff[7:0];
        wr_mem = 1'b1;
        upd_arith = 1'b1;
      end
      OP_DECREMENT_SKIP_NIL, OP_DECREMENT_SKIP_NIL_TO_W: begin
        result = operand - MCUXT_ONE;
        wr_mem = (instr_q.opcode == OP_DECREMENT_SKIP_NIL);
        wr_w = (instr_q.opcode == OP_DECREMENT_SKIP_NIL_TO_W);
        skip_cond = (result == MCUXT_BYTE_RESET);
      end
      OP_INCREMENT_SKIP_NIL, OP_INCREMENT_SKIP_NIL_TO_W: begin
        result = operand + MCUXT_ONE;
        wr_mem = (instr_q.opcode == OP_INCREMENT_SKIP_NIL);
        wr_w = (instr_q.opcode == OP_INCREMENT_SKIP_NIL_TO_W);
        skip_cond = (result == MCUXT_BYTE_RESET);
      end
      OP_SKIP_BIT_SET: skip_cond = operand[instr_q.bit_sel];
      OP_SKIP_BIT_CLEAR: skip_cond = ~operand[instr_q.bit_sel];
      OP_SKIP_IF_NIL: skip_cond = (operand == MCUXT_BYTE_RESET);
      OP_COPY_SKIP_IF_NIL: begin
        result = operand;
        wr_w = 1'b1;
        skip_cond = (operand == MCUXT_BYTE_RESET);
      end
      OP_SET_BYTE: begin
        result = MCUXT_ALL_ONES;
        wr_mem = 1'b1;
      end
      OP_SET_BIT: begin
        result = operand | (MCUXT_ONE << instr_q.bit_sel);
        wr_mem = 1'b1;
      end
      OP_NIBBLE_EXCHANGE, OP_NIBBLE_EXCHANGE_TO_W: begin
        result = {operand[3:0], operand[7:4]};
        wr_mem = (instr_q.opcode == OP_NIBBLE_EXCHANGE);
        wr_w = (instr_q.opcode == OP_NIBBLE_EXCHANGE_TO_W);
      end
      OP_TABLE_FETCH_PAGED: begin
        is_table = 1'b1;
        table_addr = {table_pointer_high_q[PA_W-9:0], table_pointer_low_q};
      end
      OP_TABLE_FETCH_CURRENT_PAGE: begin
        is_table = 1'b1;
        table_addr = {current_page, table_pointer_low_q};
      end
      OP_TABLE_FETCH_LAST_PAGE: begin
        is_table = 1'b1;
        table_addr = {{(PA_W-8){1'b1}}, table_pointer_low_q};
      end
      OP_EXCLUSIVE_OR_TO_W, OP_EXCLUSIVE_OR_IMMEDIATE: begin
        result = working_register_q ^ sub_rhs;
        wr_w = 1'b1;
        upd_zero = 1'b1;
      end
      OP_EXCLUSIVE_OR_TO_MEMORY: begin
        result = working_register_q ^ operand;
        wr_mem = 1'b1;
        upd_zero = 1'b1;
      end
      default: result = MCUXT_BYTE_RESET;
    endcase
  end

  // sequencer: execute, then dummy cycle on a skip or two cycles of table read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: if (go_q) state_q <= ST_EXEC;
        ST_EXEC: begin
          if (!exec_en) state_q <= ST_IDLE;
          else if (is_table) state_q <= ST_TREQ;
          else if (skip_cond) state_q <= ST_SKIP;
          else state_q <= ST_IDLE;
        end
        ST_SKIP: state_q <= ST_IDLE;
        ST_TREQ: state_q <= ST_TCAP;
        ST_TCAP: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // discard marker: the instruction after a taken skip is dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      discard_q <= 1'b0;
      skip_taken_q <= 1'b0;
    end else begin
      skip_taken_q <= exec_en & ~is_table & skip_cond;
      if (exec_en && !is_table && skip_cond) discard_q <= 1'b1;
      else if (state_q == ST_EXEC) discard_q <= 1'b0;
    end
  end

  // program memory request, registered so the port sees a stable address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pmem_addr_q <= '0;
      pmem_rd_q <= 1'b0;
    end else begin
      pmem_rd_q <= exec_en & is_table;
      if (exec_en && is_table) pmem_addr_q <= table_addr;
    end
  end

  // data memory: bus window, execute write-back and table low byte
  always_ff @(posedge aclk) begin
    if (exec_en && wr_mem) begin
      dmem_q[instr_q.mem_addr[DA_W-1:0]] <= result;
    end else if (state_q == ST_TCAP) begin
      dmem_q[instr_q.mem_addr[DA_W-1:0]] <= pmem_rdata[7:0];
    end else if (do_write && wsel_dmem && w_strb_q[0]) begin
      dmem_q[aw_addr_q[DA_W+1:2]] <= w_data_q[7:0];
    end
  end

  // working register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      working_register_q <= MCUXT_BYTE_RESET;
    end else if (exec_en && wr_w) begin
      working_register_q <= result;
    end else if (do_write && wsel_work && w_strb_q[0]) begin
      working_register_q <= w_data_q[7:0];
    end
  end

  // flags: borrow flag set means no borrow, i.e. result zero or positive
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= '0;
    end else if (exec_en && upd_arith) begin
      flags_q.borrow_flag <= ~diff[8];
      flags_q.half_borrow_flag <= ~half_diff[4];
      flags_q.zero_flag <= (diff[7:0] == MCUXT_BYTE_RESET);
      flags_q.signed_range_flag <= (working_register_q[7] ^ sub_rhs[7]) &
                                   (diff[7] ^ working_register_q[7]);
    end else if (exec_en && upd_zero) begin
      flags_q.zero_flag <= (result == MCUXT_BYTE_RESET);
    end else if (do_write && wsel_flags && w_strb_q[0]) begin
      flags_q <= w_data_q[3:0];
    end
  end

  // table pointers are software written, the high read byte comes from the table
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      table_pointer_low_q <= MCUXT_BYTE_RESET;
      table_pointer_high_q <= MCUXT_BYTE_RESET;
      table_read_high_byte_q <= MCUXT_BYTE_RESET;
    end else begin
      if (do_write && wsel_tlow && w_strb_q[0]) table_pointer_low_q <= w_data_q[7:0];
      if (do_write && wsel_thigh && w_strb_q[0]) table_pointer_high_q <= w_data_q[7:0];
      if (state_q == ST_TCAP) table_read_high_byte_q <= pmem_rdata[PW_W-1:PW_W-8];
    end
  end

  // outputs
  assign pmem_addr = pmem_addr_q;
  assign pmem_rd = pmem_rd_q;
  assign busy = (state_q != ST_IDLE) | go_q;
  assign skip_taken = skip_taken_q;

endmodule : mcuxt_exec

// >>> test/mcuxt_exec_monitor.sv
// port-level assertions for the instruction execute tail
`timescale 1ns/1ps
module mcuxt_exec_monitor
  import mcuxt_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus handshakes
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // program memory and fetch view
  input wire logic pmem_rd,
  input wire logic busy,
  input wire logic skip_taken
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // table strobe is a single pulse and only while executing
  property p_rd_pulse; pmem_rd |=> !pmem_rd; endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("table strobe longer than one cycle");
  property p_rd_busy; pmem_rd |-> busy; endproperty
  a_rd_busy: assert property (p_rd_busy) else $error("table strobe while idle");
  // dummy cycle of a taken skip is exactly one cycle inside the instruction
  property p_skip_pulse; skip_taken |=> !skip_taken; endproperty
  a_skip_pulse: assert property (p_skip_pulse) else $error("dummy cycle not single");
  property p_skip_busy; skip_taken |-> busy; endproperty
  a_skip_busy: assert property (p_skip_busy) else $error("dummy cycle outside instruction");
  // an instruction never hangs: worst case is the table read sequence
  property p_done; $rose(busy) |-> ##[1:8] !busy; endproperty
  a_done: assert property (p_done) else $error("instruction did not finish");
  // bus answers: one outstanding transfer each way
  property p_b_clear; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_clear: assert property (p_b_clear) else $error("write response repeated");
  property p_r_clear; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_r_clear: assert property (p_r_clear) else $error("read response repeated");
  property p_r_cause; $rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready); endproperty
  a_r_cause: assert property (p_r_cause) else $error("read data without address");
  property p_ar_ready; s_axi_arready == !s_axi_rvalid; endproperty
  a_ar_ready: assert property (p_ar_ready) else $error("read address ready wrong");

  c_skip: cover property (skip_taken);
  c_table: cover property (pmem_rd);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule : mcuxt_exec_monitor

// >>> test/mcuxt_pmem_model.sv
// program memory model answering one cycle after each strobe
`timescale 1ns/1ps
module mcuxt_pmem_model #(
  parameter int PA_W = 12,
  parameter int PW_W = 16
) (
  // clock
  input wire logic aclk,
  // read port
  input wire logic [PA_W-1:0] pmem_addr,
  input wire logic pmem_rd,
  output logic [PW_W-1:0] pmem_rdata
);
  logic [PW_W-1:0] word_q = '0;
  assign pmem_rdata = word_q;
  // fixed nibble over address, low byte inverted; toggles so a late capture fails
  always @(posedge aclk) begin
    if (pmem_rd) begin
      word_q <= PW_W'({4'hA, pmem_addr ^ 12'h0FF});
    end else begin
      word_q <= ~word_q;
    end
  end
endmodule : mcuxt_pmem_model

// >>> test/mcuxt_exec_tb_top.sv
// self-checking bench for the instruction execute tail
`timescale 1ns/1ps
module mcuxt_exec_tb_top import mcuxt_pkg::*;;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0] current_page = 4'h7;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [11:0] pmem_addr;
  logic [15:0] pmem_rdata;
  logic pmem_rd, busy, skip_taken;
  int n_errors = 0;
  int checks = 0;
  int skips = 0;

  // 125 MHz
  always #4 aclk = ~aclk;

  // protection bits and strobes stay fixed: full-word accesses only
  mcuxt_exec uut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pmem_addr,
    .pmem_rd, .pmem_rdata, .current_page, .busy, .skip_taken
  );
  mcuxt_pmem_model pmem (.aclk, .pmem_addr, .pmem_rd, .pmem_rdata);

  task automatic complete_run;
    if (n_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %0t %s got %h expected %h", $time, s, g, e);
    end
  endtask : chk

  task automatic hang;
    n_errors++;
    $display("MISMATCH %0t wait bound used up", $time);
    complete_run();
  endtask : hang

  // judged at the falling edge, released at the rising edge that took them
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic pa, pw, pb, ta, tw;
    int n;
    pa = 1'b1;
    pw = 1'b1;
    pb = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; pb; n++) begin
      if (n == 200) hang();
      @(negedge aclk);
      ta = pa && s_axi_awready;
      tw = pw && s_axi_wready;
      if (s_axi_bvalid === 1'b1) r = s_axi_bresp;
      @(posedge aclk);
      pa = pa && !ta;
      pw = pw && !tw;
      pb = s_axi_bvalid !== 1'b1;
      s_axi_awvalid <= pa;
      s_axi_wvalid <= pw;
      s_axi_bready <= pb;
    end
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic pa, pr, ta;
    int n;
    pa = 1'b1;
    pr = 1'b1;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; pr; n++) begin
      if (n == 200) hang();
      @(negedge aclk);
      ta = pa && s_axi_arready;
      pr = s_axi_rvalid !== 1'b1;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      pa = pa && !ta;
      s_axi_arvalid <= pa;
      s_axi_rready <= pr;
    end
  endtask : rd

  task automatic put(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk(32'(r), 32'(MCUXT_RESP_OKAY), "write response");
  endtask : put

  task automatic get(input logic [11:0] a, input logic [31:0] e, input string s);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e, s);
  endtask : get

  function automatic logic [11:0] ma(input logic [7:0] n);
    return {MCUXT_DMEM_SEL, n, 2'b00};
  endfunction : ma

  // issue one instruction and count dummy cycles until it is idle again
  task automatic issue(input logic [4:0] op, input logic [2:0] bs, input logic [7:0] adr,
      input logic [7:0] imm);
    mcuxt_instr_type ins;
    int n;
    ins = '{imm, adr, bs, mcuxt_opcode_type'(op)};
    put(MCUXT_REG_INSTR, 32'(ins));
    skips = 0;
    for (n = 0; n < 40; n++) begin
      @(negedge aclk);
      skips += int'(skip_taken === 1'b1);
      if (n > 3 && busy === 1'b0) break;
    end
    if (n == 40) hang();
  endtask : issue

  // execute on byte 3; after a taken skip a set-byte on byte 9 must leave no trace
  task automatic run(input logic [4:0] op, input logic [2:0] bs, input logic [7:0] imm,
      input logic [7:0] w0, m0, input logic [3:0] f0, input logic [7:0] ew, em,
      input logic [3:0] ef, input int es);
    put(MCUXT_REG_WORK, {24'h0, w0});
    put(ma(8'h03), {24'h0, m0});
    put(MCUXT_REG_FLAGS, {28'h0, f0});
    put(ma(8'h09), 32'h0);
    issue(op, bs, 8'h03, imm);
    chk(skips, es, "dummy cycles");
    if (es != 0) issue(5'h0E, 3'h0, 8'h09, 8'h00);
    get(MCUXT_REG_WORK, {24'h0, ew}, "work");
    get(ma(8'h03), {24'h0, em}, "memory");
    get(MCUXT_REG_FLAGS, {28'h0, ef}, "flags");
    get(ma(8'h09), 32'h0, "discarded write");
  endtask : run

  task automatic t_bus;
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 1; i < 7; i++) get(12'(4 * i), 32'h0, "reset value");
    rd(12'h020, d, r);
    chk(32'(r), 32'(MCUXT_RESP_SLVERR), "unmapped response");
    chk(d, 32'h0, "unmapped data");
    put(MCUXT_REG_TREAD_HIGH, 32'hC3);
    get(MCUXT_REG_TREAD_HIGH, 32'h0, "read-only byte");
  endtask : t_bus

  // borrow in and out, half borrow, overflow and zero
  task automatic t_sub;
    run(5'h02, 3'h0, 8'h00, 8'h10, 8'h20, 4'h0, 8'h10, 8'hEF, 4'h0, 0);
    run(5'h01, 3'h0, 8'h00, 8'h50, 8'h20, 4'h1, 8'h30, 8'h20, 4'h3, 0);
    run(5'h03, 3'h0, 8'h00, 8'h7F, 8'h7F, 4'h0, 8'h00, 8'h7F, 4'h7, 0);
    run(5'h04, 3'h0, 8'h00, 8'h00, 8'h01, 4'hE, 8'h00, 8'hFF, 4'h0, 0);
    run(5'h05, 3'h0, 8'h01, 8'h80, 8'h33, 4'h0, 8'h7F, 8'h33, 4'h9, 0);
  endtask : t_sub

  // counting skips wrap at both ends; flags preset all ones must survive
  task automatic t_count;
    run(5'h06, 3'h0, 8'h00, 8'h55, 8'h01, 4'hF, 8'h55, 8'h00, 4'hF, 1);
    run(5'h06, 3'h0, 8'h00, 8'h55, 8'h00, 4'hF, 8'h55, 8'hFF, 4'hF, 0);
    run(5'h07, 3'h0, 8'h00, 8'h55, 8'h01, 4'hF, 8'h00, 8'h01, 4'hF, 1);
    run(5'h08, 3'h0, 8'h00, 8'h55, 8'hFF, 4'hF, 8'h55, 8'h00, 4'hF, 1);
    run(5'h09, 3'h0, 8'h00, 8'h55, 8'hFE, 4'hF, 8'hFF, 8'hFE, 4'hF, 0);
  endtask : t_count

  task automatic t_test;
    run(5'h0A, 3'h3, 8'h00, 8'h55, 8'h08, 4'hF, 8'h55, 8'h08, 4'hF, 1);
    run(5'h0A, 3'h2, 8'h00, 8'h55, 8'h08, 4'hF, 8'h55, 8'h08, 4'hF, 0);
    run(5'h0B, 3'h3, 8'h00, 8'h55, 8'h08, 4'hF, 8'h55, 8'h08, 4'hF, 0);
    run(5'h0B, 3'h7, 8'h00, 8'h55, 8'h08, 4'hF, 8'h55, 8'h08, 4'hF, 1);
    run(5'h0C, 3'h0, 8'h00, 8'h55, 8'h00, 4'h0, 8'h55, 8'h00, 4'h0, 1);
    run(5'h0C, 3'h0, 8'h00, 8'h55, 8'h01, 4'hF, 8'h55, 8'h01, 4'hF, 0);
    run(5'h0D, 3'h0, 8'h00, 8'h55, 8'h00, 4'h0, 8'h00, 8'h00, 4'h0, 1);
    run(5'h0D, 3'h0, 8'h00, 8'h55, 8'h80, 4'hF, 8'h80, 8'h80, 4'hF, 0);
  endtask : t_test

  task automatic t_set_swap_xor;
    run(5'h0E, 3'h0, 8'h00, 8'h55, 8'h12, 4'hF, 8'h55, 8'hFF, 4'hF, 0);
    run(5'h0F, 3'h6, 8'h00, 8'h55, 8'h01, 4'hF, 8'h55, 8'h41, 4'hF, 0);
    run(5'h10, 3'h0, 8'h00, 8'h55, 8'hA5, 4'hF, 8'h55, 8'h5A, 4'hF, 0);
    run(5'h11, 3'h0, 8'h00, 8'h55, 8'hA5, 4'h0, 8'h5A, 8'hA5, 4'h0, 0);
    run(5'h15, 3'h0, 8'h00, 8'hF0, 8'hF0, 4'hB, 8'h00, 8'hF0, 4'hF, 0);
    run(5'h16, 3'h0, 8'h00, 8'h0F, 8'hF0, 4'hF, 8'h0F, 8'hFF, 4'hB, 0);
    run(5'h17, 3'h0, 8'h55, 8'hAA, 8'h00, 4'hF, 8'hFF, 8'h00, 4'hB, 0);
  endtask : t_set_swap_xor

  // pointers 05:34, current page 7, last page F; high byte tells the page apart
  task automatic t_table;
    put(MCUXT_REG_TPTR_LOW, 32'h34);
    put(MCUXT_REG_TPTR_HIGH, 32'h05);
    run(5'h12, 3'h0, 8'h00, 8'h55, 8'h00, 4'hF, 8'h55, 8'hCB, 4'hF, 0);
    get(MCUXT_REG_TREAD_HIGH, 32'hA5, "paged high byte");
    run(5'h13, 3'h0, 8'h00, 8'h55, 8'h00, 4'hF, 8'h55, 8'hCB, 4'hF, 0);
    get(MCUXT_REG_TREAD_HIGH, 32'hA7, "current page high byte");
    run(5'h14, 3'h0, 8'h00, 8'h55, 8'h00, 4'hF, 8'h55, 8'hCB, 4'hF, 0);
    get(MCUXT_REG_TREAD_HIGH, 32'hAF, "last page high byte");
  endtask : t_table

  // reset for five cycles, then the scenarios
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_bus();
    t_sub();
    t_count();
    t_test();
    t_set_swap_xor();
    t_table();
    complete_run();
  end
endmodule : mcuxt_exec_tb_top

bind mcuxt_exec mcuxt_exec_monitor u_mon (
  .aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_bvalid, .s_axi_bready, .pmem_rd, .busy, .skip_taken
);
